// ==== pkg/vic_defines.svh ====
`ifndef VIC_DEFINES_SVH
`define VIC_DEFINES_SVH
// ----------------------------------------
// device register map
// ----------------------------------------
`define VIC_A_IPH 8'hDA
`define VIC_A_IPL 8'hDB
`define VIC_A_REQ 8'hDC
`define VIC_A_MASK 8'hDD
`define VIC_A_SYS 8'hDE
`define VIC_A_PRIO 8'hFF
`define VIC_A_SRCEN 8'hD0
`define VIC_A_PEND 8'hD1
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define VIC_SYS_GIE 0
`define VIC_SYS_FIE 1
`define VIC_SYS_FLV 4:2
`define VIC_PR_A 0
`define VIC_PR_C 5
`define VIC_PR_SUBC 6
`define VIC_PR_G2 7
`define VIC_PR_G1 4
`define VIC_PR_G0 1
`define VIC_RST8 8'h00
`define VIC_RST16 16'h0000
`define VIC_RST32 32'h0000_0000
// ----------------------------------------
// group orders from prio bits 7,4,1
// ----------------------------------------
`define VIC_ORD_BCA 3'h1
`define VIC_ORD_ABC 3'h2
`define VIC_ORD_BAC 3'h3
`define VIC_ORD_CAB 3'h4
`define VIC_ORD_CBA 3'h5
`define VIC_ORD_ACB 3'h6
// ----------------------------------------
// controller apb map
// ----------------------------------------
`define VIC_H_LINK 8'h00
`define VIC_H_RDAT 8'h04
`define VIC_H_PC 8'h08
`define VIC_H_FLAGS 8'h0C
`define VIC_H_STAT 8'h10
`define VIC_H_RET 8'h14
`endif

// ==== pkg/vic_pkg.sv ====
package vic_pkg;
   typedef enum logic [3:0] {
      HS_IDLE, HS_LINK, HS_ACK, HS_PCH, HS_FLG, HS_VECH, HS_VECL, HS_RET, HS_RWAIT
   } vic_hstate_t;

   typedef struct packed {
      logic [15:0] ip;
      logic [7:0] mask;
      logic [7:0] prio;
      logic [7:0] sys;
      logic [7:0] srcen;
      logic [7:0] pend;
      logic [7:0] rdata;
      logic irq;
      logic [2:0] lvl;
      logic fast;
      logic in_fast;
      logic [15:0] vec;
   } vic_dev_st_t;

   typedef struct packed {
      vic_hstate_t st;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
      logic cmd_wr;
      logic cmd_pend;
      logic ret_pend;
      logic ack;
      logic ret;
      logic [15:0] pc;
      logic [7:0] flags;
      logic [7:0] rdata;
      logic insvc;
      logic fastsvc;
      logic [2:0] lvl;
      logic [15:0] tgt;
      logic stk_we;
      logic [7:0] stk_data;
      logic [7:0] rom_addr;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } vic_host_st_t;
endpackage

// ==== pkg/vic_if.sv ====
`timescale 1ns/1ns
interface vic_if;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   logic irq;
   logic [2:0] lvl;
   logic fast;
   logic ack;
   logic ret;
   logic [15:0] pc;
   logic [15:0] vec;

   modport dev (
      input addr, wdata, wr, rd, ack, ret, pc,
      output rdata, irq, lvl, fast, vec
   );
   modport cpu (
      output addr, wdata, wr, rd, ack, ret, pc,
      input rdata, irq, lvl, fast, vec
   );
endinterface

// ==== rtl/vic_device.sv ====
// Our own choice: the APB slave port.
`timescale 1ns/1ns
`include "vic_defines.svh"

// Behaviour
// - mask bit 0 blocks level, 1 allows
// - mask undefined; software writes before use
// - highest level first; lower vector wins inside
// - groups: A=0,1 B=2..4 C=5..7
// - bits 7,4,1 order groups A,B,C
// - bit 0 orders levels 0 and 1
// - bits 5,6 order group C and subgroup
// - priority undefined; software writes before use
// - read-only request status, one bit per level
// - reset clears all request status bits
// - disabled requests still recorded, not serviced
// - hidden pending bit, cleared after acknowledge; the code makes it readable at D1 and at the request status address DC
// - timer/detect sources use hardware-cleared pending
// - software clears pending by writing zero
// - service needs enable, unmasked, highest, source on
// - acknowledge at instruction end clears enable
// - push pc low, high, flags; fetch vector
// - vectors even, inside first 256 bytes
// - return restores state, sets global enable; the host restores pc only after a fast service and pops nothing
// - nesting: software saves mask, reenables, restores
// - fast pointer pair at DA high, DB low
// - reset clears global and fast enable bits
// - fast level swaps pointer and pc instead
module vic_device #(
   parameter logic [7:0] VEC_BASE = 8'h00,
   parameter logic [7:0] HW_CLR = 8'h1F
) (
   input wire logic pclk,
   input wire logic presetn,
   vic_if.dev v,
   input wire logic [7:0] src_set,
   output logic [7:0] req_status
);
   // vector table base must stay even and leave room for eight words
   if (VEC_BASE[0] || VEC_BASE > 8'hF0) begin : g_bad_base
      $error("vic_device: VEC_BASE must be even and at most F0");
   end

   // ----------------------------------------
   // priority helpers
   // ----------------------------------------
   function automatic logic [3:0] first3(
      input logic [7:0] c,
      input logic [2:0] i0,
      input logic [2:0] i1,
      input logic [2:0] i2
   );
      logic [3:0] r;
      r = {1'b0, i0};
      if (c[i0]) begin
         r = {1'b1, i0};
      end else if (c[i1]) begin
         r = {1'b1, i1};
      end else if (c[i2]) begin
         r = {1'b1, i2};
      end
      return r;
   endfunction

   function automatic logic [3:0] pick(input logic [7:0] c, input logic [7:0] p);
      logic [3:0] wa;
      logic [3:0] wb;
      logic [3:0] wc;
      logic [2:0] s0;
      logic [2:0] s1;
      logic [3:0] g0;
      logic [3:0] g1;
      logic [3:0] g2;
      logic [3:0] r;
      // group A, level 0 vs 1
      if (p[`VIC_PR_A]) begin
         wa = first3(c, 3'h1, 3'h0, 3'h0);
      end else begin
         wa = first3(c, 3'h0, 3'h1, 3'h1);
      end
      // group B fixed: lower level number wins
      wb = first3(c, 3'h2, 3'h3, 3'h4);
      // group C and its 6/7 subgroup
      if (p[`VIC_PR_SUBC]) begin
         s0 = 3'h7;
         s1 = 3'h6;
      end else begin
         s0 = 3'h6;
         s1 = 3'h7;
      end
      if (p[`VIC_PR_C]) begin
         wc = first3(c, s0, s1, 3'h5);
      end else begin
         wc = first3(c, 3'h5, s0, s1);
      end
      unique case ({p[`VIC_PR_G2], p[`VIC_PR_G1], p[`VIC_PR_G0]})
         `VIC_ORD_BCA: begin
            g0 = wb;
            g1 = wc;
            g2 = wa;
         end
         `VIC_ORD_CBA: begin
            g0 = wc;
            g1 = wb;
            g2 = wa;
         end
         `VIC_ORD_BAC: begin
            g0 = wb;
            g1 = wa;
            g2 = wc;
         end
         `VIC_ORD_CAB: begin
            g0 = wc;
            g1 = wa;
            g2 = wb;
         end
         `VIC_ORD_ACB: begin
            g0 = wa;
            g1 = wc;
            g2 = wb;
         end
         // the two unused codes fall back to A>B>C
         `VIC_ORD_ABC, 3'h0, 3'h7: begin
            g0 = wa;
            g1 = wb;
            g2 = wc;
         end
      endcase
      if (g0[3]) begin
         r = g0;
      end else if (g1[3]) begin
         r = g1;
      end else begin
         r = g2;
      end
      return r;
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   vic_pkg::vic_dev_st_t s_q;
   vic_pkg::vic_dev_st_t s_d;
   logic [7:0] cand;
   logic [3:0] win;
   logic [7:0] clr;
   logic [7:0] lvl_bit;

   always_comb begin
      s_d = s_q;
      clr = `VIC_RST8;
      lvl_bit = 8'h01 << s_q.lvl;
      // masked or source-disabled levels stay pending but never win
      cand = s_q.pend & s_q.srcen & s_q.mask;
      win = pick(cand, s_q.prio);

      // register reads answer one cycle later
      if (v.rd) begin
         unique case (v.addr)
            `VIC_A_IPH: s_d.rdata = s_q.ip[15:8];
            `VIC_A_IPL: s_d.rdata = s_q.ip[7:0];
            `VIC_A_REQ: s_d.rdata = s_q.pend;
            `VIC_A_MASK: s_d.rdata = s_q.mask;
            `VIC_A_SYS: s_d.rdata = s_q.sys;
            `VIC_A_PRIO: s_d.rdata = s_q.prio;
            `VIC_A_SRCEN: s_d.rdata = s_q.srcen;
            `VIC_A_PEND: s_d.rdata = s_q.pend;
            default: s_d.rdata = `VIC_RST8;
         endcase
      end

      // register writes; the request status is read-only
      if (v.wr) begin
         unique case (v.addr)
            `VIC_A_IPH: s_d.ip[15:8] = v.wdata;
            `VIC_A_IPL: s_d.ip[7:0] = v.wdata;
            `VIC_A_MASK: s_d.mask = v.wdata;
            `VIC_A_SYS: s_d.sys = v.wdata;
            `VIC_A_PRIO: s_d.prio = v.wdata;
            `VIC_A_SRCEN: s_d.srcen = v.wdata;
            // zero bits clear software-type pending only
            `VIC_A_PEND: clr = ~v.wdata & ~HW_CLR;
            default: ;
         endcase
      end

      // acknowledge: drop enable, clear hardware pending, vector
      if (v.ack) begin
         s_d.sys[`VIC_SYS_GIE] = 1'b0;
         clr = clr | (lvl_bit & HW_CLR);
         if (s_q.fast) begin
            s_d.ip = v.pc;
            s_d.vec = s_q.ip;
            s_d.in_fast = 1'b1;
         end else begin
            s_d.vec = {8'h00, VEC_BASE + {4'h0, s_q.lvl, 1'b0}};
         end
      end

      // return: enable again, swap back after a fast service
      if (v.ret) begin
         s_d.sys[`VIC_SYS_GIE] = 1'b1;
         if (s_q.in_fast) begin
            s_d.ip = v.pc;
            s_d.vec = s_q.ip;
            s_d.in_fast = 1'b0;
         end
      end

      // a new request in the clearing cycle is kept
      s_d.pend = (s_q.pend & ~clr) | src_set;

      // request line held low in the cycle after ack, until the cleared enable takes hold, to avoid a double take
      s_d.irq = s_q.sys[`VIC_SYS_GIE] & win[3] & ~v.ack;
      s_d.lvl = win[2:0];
      s_d.fast = s_q.sys[`VIC_SYS_FIE] & (s_q.sys[`VIC_SYS_FLV] == win[2:0]);
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   // mask, priority and pointer hold zero only to keep simulation defined
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q.ip <= `VIC_RST16;
         s_q.mask <= `VIC_RST8;
         s_q.prio <= `VIC_RST8;
         s_q.sys <= `VIC_RST8;
         s_q.srcen <= `VIC_RST8;
         s_q.pend <= `VIC_RST8;
         s_q.rdata <= `VIC_RST8;
         s_q.irq <= 1'b0;
         s_q.lvl <= 3'h0;
         s_q.fast <= 1'b0;
         s_q.in_fast <= 1'b0;
         s_q.vec <= `VIC_RST16;
      end else begin
         s_q <= s_d;
      end
   end

   assign v.rdata = s_q.rdata;
   assign v.irq = s_q.irq;
   assign v.lvl = s_q.lvl;
   assign v.fast = s_q.fast;
   assign v.vec = s_q.vec;
   assign req_status = s_q.pend;
endmodule

// ==== rtl/vic_host.sv ====
`timescale 1ns/1ns
`include "vic_defines.svh"

module vic_host (
   input wire logic pclk,
   input wire logic presetn,
   vic_if.cpu v,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic insn_end,
   output logic stk_we,
   output logic [7:0] stk_data,
   output logic [7:0] rom_addr,
   input wire logic [7:0] rom_rdata
);
   vic_pkg::vic_host_st_t s_q;
   vic_pkg::vic_host_st_t s_d;
   logic setup;
   logic wdone;

   always_comb begin
      s_d = s_q;
      setup = psel & ~penable;
      wdone = psel & penable & s_q.pready & pwrite;
      s_d.wr = 1'b0;
      s_d.rd = 1'b0;
      s_d.ack = 1'b0;
      s_d.ret = 1'b0;
      s_d.stk_we = 1'b0;
      // ----------------------------------------
      // apb slave, one wait-free access phase
      // ----------------------------------------
      s_d.pready = setup;
      if (setup) begin
         s_d.pslverr = 1'b0;
         unique case (paddr)
            `VIC_H_RDAT: s_d.prdata = {23'h0, s_q.cmd_pend, s_q.rdata};
            `VIC_H_PC: s_d.prdata = {16'h0, s_q.pc};
            `VIC_H_FLAGS: s_d.prdata = {24'h0, s_q.flags};
            `VIC_H_STAT: s_d.prdata = {8'h0, s_q.tgt, 3'h0, s_q.lvl, s_q.fastsvc, s_q.insvc};
            `VIC_H_LINK, `VIC_H_RET: s_d.prdata = `VIC_RST32;
            default: begin
               s_d.prdata = `VIC_RST32;
               s_d.pslverr = 1'b1;
            end
         endcase
      end
      if (wdone) begin
         unique case (paddr)
            // a link command while one is queued is dropped
            `VIC_H_LINK: if (!s_q.cmd_pend) begin
               s_d.addr = pwdata[7:0];
               s_d.wdata = pwdata[15:8];
               s_d.cmd_wr = pwdata[16];
               s_d.cmd_pend = 1'b1;
            end
            `VIC_H_PC: s_d.pc = pwdata[15:0];
            `VIC_H_FLAGS: s_d.flags = pwdata[7:0];
            `VIC_H_RET: s_d.ret_pend = s_d.ret_pend | pwdata[0];
            default: ;
         endcase
      end
      // ----------------------------------------
      // sequencer
      // ----------------------------------------
      unique case (s_q.st)
         vic_pkg::HS_IDLE: begin
            if (s_q.cmd_pend) begin
               s_d.wr = s_q.cmd_wr;
               s_d.rd = ~s_q.cmd_wr;
               s_d.st = vic_pkg::HS_LINK;
            end else if (s_q.ret_pend && s_q.insvc) begin
               s_d.st = vic_pkg::HS_RET;
            end else if (insn_end && v.irq) begin
               s_d.ack = 1'b1;
               s_d.lvl = v.lvl;
               s_d.fastsvc = v.fast;
               s_d.st = vic_pkg::HS_ACK;
            end
         end
         vic_pkg::HS_LINK: begin
            // device read data stands only from the cycle after rd
            if (!s_q.rd) begin
               if (!s_q.cmd_wr) begin
                  s_d.rdata = v.rdata;
               end
               s_d.cmd_pend = 1'b0;
               s_d.st = vic_pkg::HS_IDLE;
            end
         end
         vic_pkg::HS_ACK: begin
            s_d.insvc = 1'b1;
            if (s_q.fastsvc) begin
               // vec is loaded at the ack edge, so wait one cycle for it
               if (!s_q.ack) begin
                  s_d.pc = v.vec;
                  s_d.tgt = v.vec;
                  s_d.st = vic_pkg::HS_IDLE;
               end
            end else begin
               s_d.stk_we = 1'b1;
               s_d.stk_data = s_q.pc[7:0];
               s_d.st = vic_pkg::HS_PCH;
            end
         end
         vic_pkg::HS_PCH: begin
            s_d.stk_we = 1'b1;
            s_d.stk_data = s_q.pc[15:8];
            s_d.st = vic_pkg::HS_FLG;
         end
         vic_pkg::HS_FLG: begin
            s_d.stk_we = 1'b1;
            s_d.stk_data = s_q.flags;
            s_d.rom_addr = v.vec[7:0];
            s_d.st = vic_pkg::HS_VECH;
         end
         vic_pkg::HS_VECH: begin
            s_d.tgt[15:8] = rom_rdata;
            s_d.rom_addr = v.vec[7:0] + 8'h01;
            s_d.st = vic_pkg::HS_VECL;
         end
         vic_pkg::HS_VECL: begin
            s_d.tgt[7:0] = rom_rdata;
            s_d.pc = {s_q.tgt[15:8], rom_rdata};
            s_d.st = vic_pkg::HS_IDLE;
         end
         vic_pkg::HS_RET: begin
            s_d.ret = 1'b1;
            s_d.ret_pend = 1'b0;
            s_d.st = vic_pkg::HS_RWAIT;
         end
         vic_pkg::HS_RWAIT: begin
            // swapped pointer stands only after the ret edge
            if (!s_q.ret) begin
               if (s_q.fastsvc) begin
                  s_d.pc = v.vec;
               end
               s_d.insvc = 1'b0;
               s_d.fastsvc = 1'b0;
               s_d.st = vic_pkg::HS_IDLE;
            end
         end
         default: s_d.st = vic_pkg::HS_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign v.addr = s_q.addr;
   assign v.wdata = s_q.wdata;
   assign v.wr = s_q.wr;
   assign v.rd = s_q.rd;
   assign v.ack = s_q.ack;
   assign v.ret = s_q.ret;
   assign v.pc = s_q.pc;
   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign stk_we = s_q.stk_we;
   assign stk_data = s_q.stk_data;
   assign rom_addr = s_q.rom_addr;
endmodule

// ==== tb/vic_props.sv ====
`timescale 1ns/1ns
`include "vic_defines.svh"
module vic_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic irq,
   input wire logic [2:0] lvl,
   input wire logic fast,
   input wire logic ack,
   input wire logic ret,
   input wire logic [15:0] pc,
   input wire logic [15:0] vec
);
   // ----------------------------------------
   // shadows rebuilt from link traffic
   // ----------------------------------------
   logic [7:0] mask_q;
   logic gie_q;
   logic fsvc_q;
   logic [15:0] ip_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= 8'h00;
         gie_q <= 1'h0;
         fsvc_q <= 1'h0;
         ip_q <= 16'h0000;
      end else begin
         if (wr && addr == `VIC_A_MASK) mask_q <= wdata;
         if (wr && addr == `VIC_A_SYS) gie_q <= wdata[`VIC_SYS_GIE];
         if (wr && addr == `VIC_A_IPH) ip_q[15:8] <= wdata;
         if (wr && addr == `VIC_A_IPL) ip_q[7:0] <= wdata;
         if (ack) gie_q <= 1'h0;
         if (ack) fsvc_q <= fast;
         if (ret) gie_q <= 1'h1;
         if (ret) fsvc_q <= 1'h0;
         // both swaps hand the old pointer out and keep the pc
         if ((ack && fast) || (ret && fsvc_q)) ip_q <= pc;
      end
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_swap;
      (vec == $past(ip_q)) ##1 (pc == $past(ip_q, 2));
   endsequence
   property p_ack_clr; ack |=> !irq [*3]; endproperty
   property p_ack_cause; ack |-> $past(irq); endproperty
   property p_irq_gie; $rose(irq) |-> $past(gie_q); endproperty
   property p_irq_mask; irq |-> |($past(mask_q) & (8'h01 << lvl)); endproperty
   property p_vec_norm; ack && !fast |=> vec == {8'h00, 4'h0, $past(lvl), 1'h0}; endproperty
   property p_vec_fast; ack && fast |=> s_swap; endproperty
   property p_ret_fast; ret && fsvc_q |=> vec == $past(ip_q); endproperty
   property p_rd_mask; rd && addr == `VIC_A_MASK |=> rdata == mask_q; endproperty
   property p_rd_ptr; rd && addr == `VIC_A_IPH |=> rdata == ip_q[15:8]; endproperty
   a_ack_clr: assert property (p_ack_clr)
      else $error("irq still high after acknowledge");
   a_ack_cause: assert property (p_ack_cause)
      else $error("acknowledge without request");
   a_irq_gie: assert property (p_irq_gie)
      else $error("request raised while globally disabled");
   a_irq_mask: assert property (p_irq_mask)
      else $error("request raised for masked level");
   a_vec_norm: assert property (p_vec_norm)
      else $error("vector address wrong");
   a_vec_fast: assert property (p_vec_fast)
      else $error("fast entry swap wrong");
   a_ret_fast: assert property (p_ret_fast)
      else $error("fast return swap wrong");
   a_rd_mask: assert property (p_rd_mask)
      else $error("mask readback wrong");
   a_rd_ptr: assert property (p_rd_ptr)
      else $error("pointer high readback wrong");
endmodule

// ==== tb/vectored_interrupt_controller_tb_top.sv ====
`timescale 1ns/1ns
`include "vic_defines.svh"
module vectored_interrupt_controller_tb_top;
   typedef struct packed {
      logic [7:0] prio;
      logic [7:0] src;
      logic [11:0] ord;
   } vic_row_t;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic insn_end;
   logic stk_we;
   logic [7:0] stk_data;
   logic [7:0] rom_addr;
   logic [7:0] rom_rdata;
   logic [7:0] src_set;
   logic [7:0] req_status;
   logic [7:0] pushes [$];
   logic [31:0] rv;
   logic er;
   logic [7:0] b;
   logic [2:0] l;
   int n_errors;
   int comparisons;
   int cyc;
   vic_row_t rows [13];
   vic_if v ();
   vic_device i_vic_device (.pclk(pclk), .presetn(presetn), .v(v), .src_set(src_set),
      .req_status(req_status));
   vic_host i_vic_host (.pclk(pclk), .presetn(presetn), .v(v), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .insn_end(insn_end), .stk_we(stk_we), .stk_data(stk_data),
      .rom_addr(rom_addr), .rom_rdata(rom_rdata));
   vic_props i_vic_props (.pclk(pclk), .presetn(presetn), .addr(v.addr), .wdata(v.wdata),
      .wr(v.wr), .rd(v.rd), .rdata(v.rdata), .irq(v.irq), .lvl(v.lvl), .fast(v.fast),
      .ack(v.ack), .ret(v.ret), .pc(v.pc), .vec(v.vec));
   // ----------------------------------------
   // clock, rom, stack capture, timeout
   // ----------------------------------------
   initial begin
      pclk = 1'h0;
      forever #50 pclk = ~pclk;
   end
   // rom answers in the same cycle as its address
   assign rom_rdata = rom_addr ^ 8'hC3;
   always @(posedge pclk) begin
      if (stk_we === 1'h1) pushes.push_back(stk_data);
      cyc++;
      if (cyc == 30000) begin
         n_errors++;
         $display("BAD %0t timeout", $time);
         report_and_stop();
      end
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      rv = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic poll(input logic [7:0] a, input int bit_no, input logic want);
      do begin
         apb(1'h0, a, 32'h0000_0000);
      end while (rv[bit_no] !== want);
   endtask
   task automatic dwr(input logic [7:0] a, input logic [7:0] d);
      apb(1'h1, `VIC_H_LINK, {15'h0000, 1'h1, d, a});
      poll(`VIC_H_RDAT, 8, 1'h0);
   endtask
   task automatic drd(input logic [7:0] a);
      apb(1'h1, `VIC_H_LINK, {24'h00_0000, a});
      poll(`VIC_H_RDAT, 8, 1'h0);
      b = rv[7:0];
   endtask
   // insn_end stays low between services, except around the disabled and masked checks, so an ack only lands when polled
   task automatic serve();
      insn_end <= 1'h1;
      poll(`VIC_H_STAT, 0, 1'h1);
      insn_end <= 1'h0;
      l = rv[4:2];
   endtask
   task automatic finish_svc(input logic [2:0] lv);
      dwr(`VIC_A_PEND, ~(8'h01 << lv));
      apb(1'h1, `VIC_H_RET, 32'h0000_0001);
      poll(`VIC_H_STAT, 0, 1'h0);
   endtask
   task automatic pulse(input logic [7:0] s);
      @(posedge pclk);
      src_set <= s;
      @(posedge pclk);
      src_set <= 8'h00;
   endtask
   task automatic report_and_stop();
      if (n_errors == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {psel, penable, pwrite, insn_end, er} = 5'h00;
      {paddr, src_set} = 16'h0000;
      pwdata = 32'h0000_0000;
      presetn = 1'h0;
      rows = '{'{8'h02, 8'h4A, 12'h361}, '{8'h10, 8'h4A, 12'h136}, '{8'h12, 8'h4A, 12'h316},
         '{8'h80, 8'h4A, 12'h613}, '{8'h82, 8'h4A, 12'h631}, '{8'h90, 8'h4A, 12'h163},
         '{8'h00, 8'h4A, 12'h136}, '{8'h92, 8'h4A, 12'h136}, '{8'h11, 8'h07, 12'h102},
         '{8'h10, 8'h07, 12'h012}, '{8'h10, 8'hE0, 12'h567}, '{8'h70, 8'hE0, 12'h765},
         '{8'h82, 8'h1C, 12'h234}};
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      dwr(`VIC_A_MASK, 8'hFF);
      dwr(`VIC_A_SRCEN, 8'hFF);
      dwr(`VIC_A_SYS, 8'h01);
      foreach (rows[i]) begin
         dwr(`VIC_A_PRIO, rows[i].prio);
         pulse(rows[i].src);
         for (int j = 2; j >= 0; j--) begin
            serve();
            chk(l, rows[i].ord[j*4 +: 3], "service order");
            chk(req_status[l], l > 3'h4, "pending after ack");
            finish_svc(l);
         end
         chk(req_status, 8'h00, "pending left");
      end
      // stacked entry: pc low, pc high, flags, then vector bytes high, low
      apb(1'h1, `VIC_H_PC, 32'h0000_1234);
      apb(1'h1, `VIC_H_FLAGS, 32'h0000_005A);
      pushes.delete();
      pulse(8'h08);
      serve();
      // target is complete only after both vector bytes are fetched
      apb(1'h0, `VIC_H_STAT, 32'h0000_0000);
      chk({8'(pushes.size()), pushes[0], pushes[1], pushes[2]}, 32'h0334_125A, "stack");
      chk(rv[23:8], {8'h06 ^ 8'hC3, 8'h07 ^ 8'hC3}, "target");
      finish_svc(3'h3);
      // fast level 2: pointer and pc swap on entry and on return
      dwr(`VIC_A_IPH, 8'hAB);
      dwr(`VIC_A_IPL, 8'hCD);
      dwr(`VIC_A_SYS, 8'h0B);
      apb(1'h1, `VIC_H_PC, 32'h0000_4321);
      pulse(8'h04);
      serve();
      chk(rv[1], 1'h1, "fast flag");
      apb(1'h0, `VIC_H_PC, 32'h0000_0000);
      chk(rv[15:0], 16'hABCD, "fast entry pc");
      finish_svc(3'h2);
      apb(1'h0, `VIC_H_PC, 32'h0000_0000);
      chk(rv[15:0], 16'h4321, "fast return pc");
      drd(`VIC_A_IPH);
      chk(b, 8'hAB, "pointer high");
      // disabled and masked requests are recorded but not taken
      dwr(`VIC_A_SYS, 8'h00);
      insn_end <= 1'h1;
      pulse(8'h10);
      repeat (10) @(posedge pclk);
      apb(1'h0, `VIC_H_STAT, 32'h0000_0000);
      chk(rv[0], 1'h0, "serviced while disabled");
      drd(`VIC_A_REQ);
      chk(b, 8'h10, "request status");
      // mask changed first while disabled, as a nesting routine does, and restored to FF after re-enabling
      dwr(`VIC_A_MASK, 8'hEF);
      drd(`VIC_A_MASK);
      chk(b, 8'hEF, "mask readback");
      dwr(`VIC_A_SYS, 8'h01);
      repeat (10) @(posedge pclk);
      apb(1'h0, `VIC_H_STAT, 32'h0000_0000);
      chk(rv[0], 1'h0, "serviced while masked");
      insn_end <= 1'h0;
      dwr(`VIC_A_MASK, 8'hFF);
      serve();
      chk(l, 3'h4, "unmasked level");
      finish_svc(3'h4);
      drd(`VIC_A_SYS);
      chk(b[0], 1'h1, "enable after return");
      // second reset in mid-run with a request outstanding
      pulse(8'h80);
      @(posedge pclk);
      presetn <= 1'h0;
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      chk(req_status, 8'h00, "status after reset");
      drd(`VIC_A_SYS);
      chk(b[1:0], 2'h0, "enables after reset");
      dwr(`VIC_A_REQ, 8'hFF);
      drd(`VIC_A_REQ);
      chk(b, 8'h00, "status written");
      apb(1'h0, 8'h20, 32'h0000_0000);
      chk(er, 1'h1, "unmapped host address");
      report_and_stop();
   end
endmodule
